// ==== sim/bcc_host_model.sv ====
// Purpose: Host side of the buck control register port
// Assumes: Single-byte accesses, requests launched at the rising edge
// Notes:   Idle write data is inverted so a stale byte can never pass as valid
`timescale 1ns/1ps
module bcc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData
);
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrEn   <= 1'b1;
    regWrData <= d;
    @(posedge clk);
    regWrEn   <= 1'b0;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1 d = regRdData;
  endtask
endmodule // bcc_host_model

// ==== sim/bcc_regs_tb_top.sv ====
// Purpose: Self-checking bench for the buck control register bank
// Assumes: Outputs settle within one cycle of a register update
// Notes:   Slew rate of code 7 is not compared, only the immediate flag
`timescale 1ns/1ps
module bcc_regs_tb_top;
  import bcc_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        p1 = 1'b0, p2 = 1'b0, p3 = 1'b0, wEn;
  logic [7:0]  addr, wD, rD, rv, m;
  logic        e1, r1, l1, d1, i1, e2, r2, l2, d2, i2;
  logic [1:0]  ph;
  logic [11:0] v1, s1, v2, s2;
  logic [4:0]  c;
  logic [2:0]  t;
  int          n_fail = 0, tests_run = 0;
  always #10 clk = ~clk;
  bcc_host_model bcc_host_model_i(.clk(clk), .regRdData(rD), .regAddr(addr), .regWrEn(wEn), .regWrData(wD));
  bcc_regs #(.CODE_W(5)) bcc_regs_i(.clk(clk), .sys_rst(sys_rst), .regAddr(addr), .regWrEn(wEn),
    .regWrData(wD), .regRdData(rD), .pinOneLevel(p1), .pinTwoLevel(p2), .pinThreeLevel(p3),
    .buckOneEnable(e1), .buckOneRipplePriority(r1), .buckOneLightLoadDisable(l1),
    .buckOneDischargeEnable(d1), .buckClockPhase(ph), .buckOneTargetMv(v1), .buckOneSlewRate(s1),
    .buckOneSlewImmediate(i1), .buckTwoEnable(e2), .buckTwoRipplePriority(r2),
    .buckTwoLightLoadDisable(l2), .buckTwoDischargeEnable(d2), .buckTwoTargetMv(v2),
    .buckTwoSlewRate(s2), .buckTwoSlewImmediate(i2));
  // ----------------------------------------------------------------
  // Expectations and reporting
  // ----------------------------------------------------------------
  function automatic logic [11:0] mv(input bit two, input logic [4:0] k);
    if (k == 5'h1F) k = 5'h00;
    return two ? 12'(1000 + 80 * k) : 12'(600 + 40 * k);
  endfunction
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(36));
    {p3, p2, p1} <= 3'($urandom);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      m = (i == 2) ? {p3, p2, p1, 5'h10} : (i == 1 ? 8'h16 : (i == 4 ? 8'h06 : (i == 0 ? 8'h10 : 8'h1D)));
      bcc_host_model_i.rd(ADDR_B1_CTL + 8'(i), rv);
      chk(12'(rv), 12'(m));
    end
    chk(v1, 12'd1240);
    chk(s2, 12'd3072);
    chk(v2, 12'd3320);
    for (int k = 0; k < 32; k++) begin
      c = 5'(k);
      t = 3'($urandom);
      bcc_host_model_i.wr(ADDR_B1_CTL, {t, c});
      bcc_host_model_i.wr(ADDR_B2_CTL, {~t, c});
      bcc_host_model_i.rd(ADDR_B2_CTL, rv);
      chk(v1, mv(0, c));
      chk(v2, mv(1, c));
      chk(12'(rv), 12'({~t, c}));
      chk(12'({e1, r1, l1, e2, r2, l2}), 12'({t, ~t}));
    end
    for (int k = 0; k < 8; k++) begin
      rv = (8'($urandom) & 8'hB8) | 8'(k);
      bcc_host_model_i.wr(ADDR_B1_MODE, rv);
      bcc_host_model_i.wr(ADDR_B2_MODE, rv);
      bcc_host_model_i.rd(ADDR_B2_MODE, m);
      chk(12'(m), 12'(rv & 8'h67));
      chk(12'({ph, d1, d2, i1, i2}), 12'({rv[4:3], rv[5], rv[5], k == 7, k == 7}));
      if (k < 7) chk(s2, 12'(48 << k));
      if (k < 7) chk(s1, 12'(24 << k));
    end
    for (int k = 0; k < 4; k++) begin
      c = 5'($urandom);
      @(posedge clk);
      {p3, p2, p1} <= 3'($urandom);
      bcc_host_model_i.wr(ADDR_B1_SBY, {3'b111, c});
      bcc_host_model_i.wr(ADDR_B2_SBY, {3'b111, ~c});
      bcc_host_model_i.wr(ADDR_B1_MODE, {1'b0, k[0], 6'h00});
      bcc_host_model_i.wr(ADDR_B2_MODE, {1'b0, k[0], 6'h00});
      bcc_host_model_i.rd(ADDR_B1_SBY, rv);
      chk(12'(rv), 12'({p3, p2, p1, c}));
      chk(v1, k[0] ? mv(0, c) : mv(0, 5'h1F));
      chk(v2, k[0] ? mv(1, ~c) : mv(1, 5'h1F));
    end
    bcc_host_model_i.wr(8'h16, 8'hFF);
    bcc_host_model_i.rd(8'h16, rv);
    chk(12'(rv), 12'h000);
    // Mid-run reset must bring the standby code back to its power-up value
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    bcc_host_model_i.rd(ADDR_B1_SBY, rv);
    chk(12'(rv), 12'({p3, p2, p1, 5'h10}));
    chk(v1, 12'd1240);
    results();
  end
endmodule // bcc_regs_tb_top

// ==== verilog/bcc_pkg.sv ====
// Purpose: Shared constants for the buck converter control register bank
// Assumes: 8-bit register space reached through the device register port
// Notes:   Voltages in mV, slew rates in units of 0.01 mV/us
package bcc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_B1_CTL     = 8'h10;
  localparam logic [7:0] ADDR_B1_MODE    = 8'h11;
  localparam logic [7:0] ADDR_B1_SBY     = 8'h12;
  localparam logic [7:0] ADDR_B2_CTL     = 8'h13;
  localparam logic [7:0] ADDR_B2_MODE    = 8'h14;
  localparam logic [7:0] ADDR_B2_SBY     = 8'h15;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int         BIT_EN          = 7;
  localparam int         BIT_RIPPLE      = 6;
  localparam int         BIT_LIGHT_DIS   = 5;
  localparam int         BIT_SBY_SEL     = 6;
  localparam int         BIT_DISCH       = 5;
  localparam int         BIT_PHASE_HI    = 4;
  localparam int         BIT_PHASE_LO    = 3;
  localparam logic [7:0] MASK_B1_MODE    = 8'h7F;
  localparam logic [7:0] MASK_B2_MODE    = 8'h67;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_B1_CTL      = 8'h10;
  localparam logic [7:0] RST_B1_MODE     = 8'h16;
  localparam logic [4:0] RST_B1_SBY      = 5'h10;
  localparam logic [7:0] RST_B2_CTL      = 8'h1D;
  localparam logic [7:0] RST_B2_MODE     = 8'h06;
  localparam logic [4:0] RST_B2_SBY      = 5'h1D;
  // ----------------------------------------------------------------
  // Decode tables
  // ----------------------------------------------------------------
  localparam logic [11:0] B1_BASE_MV     = 12'h258;
  localparam logic [11:0] B1_STEP_MV     = 12'h028;
  localparam logic [11:0] B2_BASE_MV     = 12'h3E8;
  localparam logic [11:0] B2_STEP_MV     = 12'h050;
  localparam logic [11:0] B1_SLEW_BASE   = 12'h018;
  localparam logic [11:0] B2_SLEW_BASE   = 12'h030;
  localparam logic [2:0]  SLEW_IMMEDIATE = 3'h7;
endpackage

// ==== verilog/bcc_regs.sv ====
// Purpose: Control register bank for two buck converters
// Assumes: Register port driven by the serial protocol engine, one access per cycle
// Notes:   Read data appears one cycle after the address
//
// Functional notes
// - Pin levels three, two and one read live in bits 7..5 of the first standby register, read-only.
// - Each 5-bit voltage code decodes through one table, 0.6-1.8 V and 1-3.4 V, with all-ones wrapping low.
// - The first converter's standby code resets to the code for 1.24 V at address 12.
// - Converter two slew rates double per code, 111 is immediate and 110 (30.72) is the reset value.
// - Converter two slew code 011 gives 3.84 and code 001 follows the doubling at 0.96.
`timescale 1ns/1ps
module bcc_regs
  import bcc_pkg::*;
#(
  parameter int CODE_W = 5
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData,
  input  wire logic        pinOneLevel,
  input  wire logic        pinTwoLevel,
  input  wire logic        pinThreeLevel,
  output logic             buckOneEnable,
  output logic             buckOneRipplePriority,
  output logic             buckOneLightLoadDisable,
  output logic             buckOneDischargeEnable,
  output logic [1:0]       buckClockPhase,
  output logic [11:0]      buckOneTargetMv,
  output logic [11:0]      buckOneSlewRate,
  output logic             buckOneSlewImmediate,
  output logic             buckTwoEnable,
  output logic             buckTwoRipplePriority,
  output logic             buckTwoLightLoadDisable,
  output logic             buckTwoDischargeEnable,
  output logic [11:0]      buckTwoTargetMv,
  output logic [11:0]      buckTwoSlewRate,
  output logic             buckTwoSlewImmediate
);

  // Elaboration-time guard: the decode table is sized for 5-bit codes only
  if (CODE_W != 5) begin : g_code_w_check
    $error("bcc_regs: voltage table serves 5-bit codes only");
  end

  logic [7:0] b1Ctl_r;
  logic [7:0] b1Mode_r;
  logic [4:0] b1Sby_r;
  logic [7:0] b2Ctl_r;
  logic [7:0] b2Mode_r;
  logic [4:0] b2Sby_r;
  logic [7:0] rdData_nxt;
  logic [4:0] b1Code;
  logic [4:0] b2Code;

  // ----------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------
  function automatic logic [11:0] decodeMv(input logic [4:0] code, input logic [11:0] base,
                                           input logic [11:0] step);
    logic [4:0] idx;
    idx = (code == 5'h1F) ? 5'h00 : code; // All-ones wraps to the lowest setting
    return 12'(base + step * {7'h00, idx});
  endfunction

  function automatic logic [11:0] decodeSlew(input logic [2:0] code, input logic [11:0] base);
    return 12'(base << code); // Pure doubling, so code 001 is twice code 000
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b1Ctl_r  <= RST_B1_CTL;
      b1Mode_r <= RST_B1_MODE;
      b1Sby_r  <= RST_B1_SBY;
      b2Ctl_r  <= RST_B2_CTL;
      b2Mode_r <= RST_B2_MODE;
      b2Sby_r  <= RST_B2_SBY;
    end else if (regWrEn) begin
      unique case (regAddr)
        ADDR_B1_CTL:  b1Ctl_r  <= regWrData;
        ADDR_B1_MODE: b1Mode_r <= regWrData & MASK_B1_MODE;
        ADDR_B1_SBY:  b1Sby_r  <= regWrData[4:0]; // Upper bits are pin levels, writes ignored
        ADDR_B2_CTL:  b2Ctl_r  <= regWrData;
        ADDR_B2_MODE: b2Mode_r <= regWrData & MASK_B2_MODE;
        ADDR_B2_SBY:  b2Sby_r  <= regWrData[4:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    unique case (regAddr)
      ADDR_B1_CTL:  rdData_nxt = b1Ctl_r;
      ADDR_B1_MODE: rdData_nxt = b1Mode_r;
      ADDR_B1_SBY:  rdData_nxt = {pinThreeLevel, pinTwoLevel, pinOneLevel, b1Sby_r};
      ADDR_B2_CTL:  rdData_nxt = b2Ctl_r;
      ADDR_B2_MODE: rdData_nxt = b2Mode_r;
      ADDR_B2_SBY:  rdData_nxt = {3'h0, b2Sby_r};
      default:      rdData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) regRdData <= 8'h00;
    else         regRdData <= rdData_nxt;
  end

  // ----------------------------------------------------------------
  // Converter controls
  // ----------------------------------------------------------------
  // Standby select swaps in the standby code; no ramp between the two here
  assign b1Code = b1Mode_r[BIT_SBY_SEL] ? b1Sby_r : b1Ctl_r[4:0];
  assign b2Code = b2Mode_r[BIT_SBY_SEL] ? b2Sby_r : b2Ctl_r[4:0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buckOneTargetMv <= decodeMv(RST_B1_CTL[4:0], B1_BASE_MV, B1_STEP_MV);
      buckTwoTargetMv <= decodeMv(RST_B2_CTL[4:0], B2_BASE_MV, B2_STEP_MV);
      buckOneSlewRate <= decodeSlew(RST_B1_MODE[2:0], B1_SLEW_BASE);
      buckTwoSlewRate <= decodeSlew(RST_B2_MODE[2:0], B2_SLEW_BASE);
    end else begin
      buckOneTargetMv <= decodeMv(b1Code, B1_BASE_MV, B1_STEP_MV);
      buckTwoTargetMv <= decodeMv(b2Code, B2_BASE_MV, B2_STEP_MV);
      buckOneSlewRate <= decodeSlew(b1Mode_r[2:0], B1_SLEW_BASE);
      buckTwoSlewRate <= decodeSlew(b2Mode_r[2:0], B2_SLEW_BASE);
    end
  end

  assign buckOneEnable           = b1Ctl_r[BIT_EN];
  assign buckOneRipplePriority   = b1Ctl_r[BIT_RIPPLE];
  assign buckOneLightLoadDisable = b1Ctl_r[BIT_LIGHT_DIS];
  assign buckOneDischargeEnable  = b1Mode_r[BIT_DISCH];
  assign buckClockPhase          = {b1Mode_r[BIT_PHASE_HI], b1Mode_r[BIT_PHASE_LO]};
  assign buckOneSlewImmediate    = (b1Mode_r[2:0] == SLEW_IMMEDIATE);
  assign buckTwoEnable           = b2Ctl_r[BIT_EN];
  assign buckTwoRipplePriority   = b2Ctl_r[BIT_RIPPLE];
  assign buckTwoLightLoadDisable = b2Ctl_r[BIT_LIGHT_DIS];
  assign buckTwoDischargeEnable  = b2Mode_r[BIT_DISCH];
  assign buckTwoSlewImmediate    = (b2Mode_r[2:0] == SLEW_IMMEDIATE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pin_level_read: assert property (@(posedge clk) disable iff (sys_rst)
    regAddr == ADDR_B1_SBY |=> regRdData[7:5] == {$past(pinThreeLevel), $past(pinTwoLevel), $past(pinOneLevel)})
    else $error("pin levels not reported in bits 7..5");

  a_pin_write_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    regWrEn && regAddr == ADDR_B1_SBY |=> b1Sby_r == $past(regWrData[4:0]))
    else $error("standby code write misplaced");

  a_wrap_lowest: assert property (@(posedge clk) disable iff (sys_rst)
    b1Code == 5'h1F && b2Code == 5'h1F |=> buckOneTargetMv == 12'h258 && buckTwoTargetMv == 12'h3E8)
    else $error("all-ones code did not wrap to lowest voltage");

  a_top_voltage: assert property (@(posedge clk) disable iff (sys_rst)
    b1Code == 5'h1E |=> buckOneTargetMv == 12'h708)
    else $error("converter one top code not 1.8 V");

  a_two_top: assert property (@(posedge clk) disable iff (sys_rst)
    b2Code == 5'h1E |=> buckTwoTargetMv == 12'hD48)
    else $error("converter two top code not 3.4 V");

  a_one_bottom: assert property (@(posedge clk) disable iff (sys_rst)
    b1Code == 5'h00 |=> buckOneTargetMv == 12'h258)
    else $error("converter one code zero not 0.6 V");

  a_two_bottom: assert property (@(posedge clk) disable iff (sys_rst)
    b2Code == 5'h00 |=> buckTwoTargetMv == 12'h3E8)
    else $error("converter two code zero not 1 V");

  a_standby_reset: assert property (@(posedge clk)
    sys_rst ##1 !sys_rst |-> b1Sby_r == 5'h10 && decodeMv(b1Sby_r, B1_BASE_MV, B1_STEP_MV) == 12'h4D8)
    else $error("standby code after reset not 1.24 V");

  a_slew_default: assert property (@(posedge clk)
    sys_rst ##1 !sys_rst |-> buckTwoSlewRate == 12'hC00 && !buckTwoSlewImmediate)
    else $error("converter two slew default not 30.72");

  a_slew_immediate: assert property (@(posedge clk) disable iff (sys_rst)
    regWrEn && regAddr == ADDR_B2_MODE && regWrData[2:0] == 3'h7 |=> buckTwoSlewImmediate)
    else $error("code 111 not immediate");

  a_slew_not_immediate: assert property (@(posedge clk) disable iff (sys_rst)
    regWrEn && regAddr == ADDR_B2_MODE && regWrData[2:0] != 3'h7 |=> !buckTwoSlewImmediate)
    else $error("code other than 111 flagged immediate");

  a_slew_six: assert property (@(posedge clk) disable iff (sys_rst)
    b2Mode_r[2:0] == 3'h6 ##1 b2Mode_r[2:0] == 3'h6 |-> buckTwoSlewRate == 12'hC00)
    else $error("slew code 110 not 30.72");

  a_slew_four: assert property (@(posedge clk) disable iff (sys_rst)
    b2Mode_r[2:0] == 3'h4 ##1 b2Mode_r[2:0] == 3'h4 |-> buckTwoSlewRate == 12'h300)
    else $error("slew code 100 not 7.68");

  a_slew_three: assert property (@(posedge clk) disable iff (sys_rst)
    b2Mode_r[2:0] == 3'h3 ##1 b2Mode_r[2:0] == 3'h3 |-> buckTwoSlewRate == 12'h180)
    else $error("slew code 011 not 3.84");

  a_slew_one: assert property (@(posedge clk) disable iff (sys_rst)
    b2Mode_r[2:0] == 3'h1 ##1 b2Mode_r[2:0] == 3'h1 |-> buckTwoSlewRate == 12'h060)
    else $error("slew code 001 not 0.96");

  a_standby_select: assert property (@(posedge clk) disable iff (sys_rst)
    b2Mode_r[BIT_SBY_SEL] |=> buckTwoTargetMv == decodeMv($past(b2Sby_r), B2_BASE_MV, B2_STEP_MV))
    else $error("standby select did not choose standby code");

  a_normal_select: assert property (@(posedge clk) disable iff (sys_rst)
    !b1Mode_r[BIT_SBY_SEL] |=> buckOneTargetMv == decodeMv($past(b1Ctl_r[4:0]), B1_BASE_MV, B1_STEP_MV))
    else $error("cleared select did not return to normal code");

  a_standby_one: assert property (@(posedge clk) disable iff (sys_rst)
    b1Mode_r[BIT_SBY_SEL] |=> buckOneTargetMv == decodeMv($past(b1Sby_r), B1_BASE_MV, B1_STEP_MV))
    else $error("converter one standby select did not choose standby code");

  a_normal_two: assert property (@(posedge clk) disable iff (sys_rst)
    !b2Mode_r[BIT_SBY_SEL] |=> buckTwoTargetMv == decodeMv($past(b2Ctl_r[4:0]), B2_BASE_MV, B2_STEP_MV))
    else $error("converter two cleared select did not use normal code");

endmodule // bcc_regs
